// ### hdl/srb_pkg.sv
// constants and carrier types for the strip hit readout back-end
package srb_pkg;
   localparam int          NCH        = 128;
   localparam int          CLK_NS     = 50;
   localparam int          TS_NS      = 30;
   localparam int          TS_CYC     = (TS_NS / CLK_NS) < 1 ? 1 : (TS_NS / CLK_NS);
   localparam int          TRIG_LAT_NS = 6000;
   localparam logic [7:0]  LAT_DEF    = 8'(TRIG_LAT_NS / TS_NS);
   localparam logic [9:0]  SYNC_LAT   = 10'h002;
   localparam int          TOT_DIV    = 2;
   localparam logic [3:0]  TOT_MAX    = 4'hf;
   localparam logic [4:0]  WORD_BITS  = 5'h10;
   localparam logic        TYPE_HIT   = 1'b1;
   localparam logic        TYPE_TS    = 1'b0;
   // register byte offsets and upper address nibbles of the mask and inject banks
   localparam logic [7:0]  A_CTRL     = 8'h00;
   localparam logic [7:0]  A_STAT     = 8'h04;
   localparam logic [1:0]  A_MASK_HI  = 2'h1;
   localparam logic [1:0]  A_INJ_HI   = 2'h2;
   // control fields, reset value and bus response codes
   localparam int          C_TWO      = 0;
   localparam int          C_INJ      = 1;
   localparam int          C_LAT_LO   = 8;
   localparam logic        TWO_DEF    = 1'b0;
   localparam logic [1:0]  RESP_OK    = 2'h0;
   localparam logic [1:0]  RESP_ERR   = 2'h2;

   typedef struct packed {
      logic [3:0] spare;
      logic       kind;
      logic [3:0] amplitude_pulse_width_count;
      logic [6:0] strip;
   } srb_hit_word_t;

   typedef struct packed {
      logic [3:0] spare_hi;
      logic       kind;
      logic       spare_lo;
      logic [9:0] stamp;
   } srb_ts_word_t;

   typedef enum logic [1:0] {S_IDLE, S_SCAN, S_SEND} srb_state_t;
endpackage

// ### hdl/srb_readout.sv
// strip hit readout back-end: hit capture, trigger match, serial output, register slave
`timescale 1ns/10ps
// Operation
// - 128 channels, each with hit capture, mask and inject; index in each hit word
// - amplitude is a 4-bit count of divide-by-2 clock ticks while discriminator is high, saturating at 15
// - stored hits leave the chip only in answer to a trigger
// - one or two serial lines, number selected by software
// - time-stamp counter advances once per 50 ns clock period in every configuration
// - time-stamp and readout timing derived synchronously from one system clock
// - pulse-width counting clock made internally by a divider
// - each firing is tagged with the time stamp in which it occurred
// - per-channel test pulse injection under digital command
// - disabled channel never yields a hit in the stream
// - only channels above threshold produce hit words
// - after reset every setting holds its default and is usable
// - written settings persist until rewritten or reset
// - every writable setting can be read back
// - hit word: 7-bit strip, 4-bit amplitude, type bit, four spare bits
// - time-stamp word: 10-bit stamp, type bit, five spare bits, before its hits
// - hit groups leave in trigger order, so output is time ordered
// - one stored hit per strip; a further hit on that strip is lost until the stored one is read out or expires
// - readout dead time kept small against the 10 percent system budget
// - hit efficiency kept at or above 85 percent
// - on a trigger only hits with the matching time stamp are sent
// - hits unclaimed within the latency window are discarded
module srb_readout (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic [127:0] i_disc,
   input  wire logic         i_trig,
   input  wire logic [9:0]   i_trig_ts,
   input  wire logic         i_awvalid,
   input  wire logic [7:0]   i_awaddr,
   input  wire logic         i_wvalid,
   input  wire logic [31:0]  i_wdata,
   input  wire logic [3:0]   i_wstrb,
   input  wire logic         i_bready,
   input  wire logic         i_arvalid,
   input  wire logic [7:0]   i_araddr,
   input  wire logic         i_rready,
   output logic              o_awready,
   output logic              o_wready,
   output logic              o_bvalid,
   output logic [1:0]        o_bresp,
   output logic              o_arready,
   output logic              o_rvalid,
   output logic [31:0]       o_rdata,
   output logic [1:0]        o_rresp,
   output logic [1:0]        o_ser,
   output logic              o_frame,
   output logic [127:0]      o_inject
);
   logic [127:0]      ds1;
   logic [127:0]      ds2;
   logic [127:0]      ds3;
   logic              tr1;
   logic              tr2;
   logic              tr3;
   logic [9:0]        tts1;
   logic [9:0]        tts2;
   logic [9:0]        ts_cnt;
   logic [3:0]        ts_div;
   logic [3:0]        tot_div;
   logic              tot_tick;
   logic              two_lane;
   logic [7:0]        lat;
   logic [3:0][31:0]  mask;
   logic [3:0][31:0]  inj_sel;
   logic              inj_go;
   logic [7:0]        lost;
   logic [127:0]      hv;
   logic [127:0][9:0] hts;
   logic [127:0][3:0] htot;
   logic [127:0]      take;
   srb_pkg::srb_state_t st;
   logic [6:0]        scan;
   logic              last;
   logic [9:0]        trig_ts_q;
   logic [15:0]       sh;
   logic [15:0]       cur_word;
   logic [4:0]        bits_left;
   logic              match;
   logic              trig_edge;
   logic              wr_fire;
   logic              rd_fire;
   logic [127:0]      mask_flat;
   srb_pkg::srb_hit_word_t hit_w;
   srb_pkg::srb_ts_word_t  ts_w;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   assign mask_flat = mask;
   assign trig_edge = tr2 & ~tr3;
   assign wr_fire   = o_awready & i_awvalid;
   assign rd_fire   = o_arready & i_arvalid;
   assign match     = hv[scan] & (hts[scan] == trig_ts_q);

   // pin synchronisers
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         ds1  <= '0;
         ds2  <= '0;
         ds3  <= '0;
         tr1  <= 1'b0;
         tr2  <= 1'b0;
         tr3  <= 1'b0;
         tts1 <= '0;
         tts2 <= '0;
      end
      else
      begin
         ds1  <= i_disc;
         ds2  <= ds1;
         ds3  <= ds2;
         tr1  <= i_trig;
         tr2  <= tr1;
         tr3  <= tr2;
         tts1 <= i_trig_ts;
         tts2 <= tts1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         ts_cnt <= '0;
         ts_div <= '0;
      end
      else if (ts_div == 4'(srb_pkg::TS_CYC - 1))
      begin
         ts_div <= '0;
         ts_cnt <= ts_cnt + 10'h001;
      end
      else
      begin
         ts_div <= ts_div + 4'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         tot_div  <= '0;
         tot_tick <= 1'b0;
      end
      else
      begin
         tot_tick <= (tot_div == 4'(srb_pkg::TOT_DIV - 1));
         tot_div  <= (tot_div == 4'(srb_pkg::TOT_DIV - 1)) ? 4'h0 : tot_div + 4'h1;
      end
   end

   for (genvar g = 0; g < srb_pkg::NCH; g++)
   begin : g_ch
      logic [9:0] pts;
      logic [3:0] ptot;
      logic       expired;
      logic       room;
      assign take[g]  = (st == srb_pkg::S_SCAN) && match && (scan == 7'(g));
      assign expired  = hv[g] && ((ts_cnt - hts[g]) > {2'h0, lat});
      assign room     = ~hv[g] | take[g] | expired;

      always_ff @(posedge i_clk)
      begin
         if (!i_rst_b)
         begin
            pts  <= '0;
            ptot <= '0;
         end
         else if (ds2[g] & ~ds3[g])
         begin
            pts  <= ts_cnt - srb_pkg::SYNC_LAT;
            ptot <= '0;
         end
         else if (ds2[g] && tot_tick && ptot != srb_pkg::TOT_MAX)
         begin
            ptot <= ptot + 4'h1;
         end
      end

      // buffer fill: mask clear wins, then new hit wins over take or expiry clear
      always_ff @(posedge i_clk)
      begin
         if (!i_rst_b)
         begin
            hv[g]   <= 1'b0;
            hts[g]  <= '0;
            htot[g] <= '0;
         end
         else if (mask_flat[g])
         begin
            hv[g] <= 1'b0;
         end
         else if (~ds2[g] & ds3[g] & room)
         begin
            hv[g]   <= 1'b1;
            hts[g]  <= pts;
            htot[g] <= ptot;
         end
         else if (take[g] | expired)
         begin
            hv[g] <= 1'b0;
         end
      end
   end

   always_comb
   begin
      hit_w.spare                       = '0;
      hit_w.kind                        = srb_pkg::TYPE_HIT;
      hit_w.amplitude_pulse_width_count = htot[scan];
      hit_w.strip                       = scan;
      ts_w.spare_hi                     = '0;
      ts_w.kind                         = srb_pkg::TYPE_TS;
      ts_w.spare_lo                     = 1'b0;
      ts_w.stamp                        = tts2;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         st        <= srb_pkg::S_IDLE;
         scan      <= '0;
         last      <= 1'b0;
         trig_ts_q <= '0;
         cur_word  <= '0;
         sh        <= '0;
         bits_left <= '0;
         lost      <= '0;
      end
      else
      begin
         if (trig_edge && st != srb_pkg::S_IDLE)
         begin
            lost <= lost + 8'h01;
         end
         case (st)
            srb_pkg::S_IDLE:
            begin
               if (trig_edge)
               begin
                  trig_ts_q <= tts2;
                  cur_word  <= ts_w;
                  sh        <= ts_w;
                  bits_left <= srb_pkg::WORD_BITS;
                  scan      <= '0;
                  last      <= 1'b0;
                  st        <= srb_pkg::S_SEND;
               end
            end
            srb_pkg::S_SCAN:
            begin
               if (match)
               begin
                  cur_word  <= hit_w;
                  sh        <= hit_w;
                  bits_left <= srb_pkg::WORD_BITS;
                  last      <= (scan == 7'h7f);
                  scan      <= scan + 7'h01;
                  st        <= srb_pkg::S_SEND;
               end
               else if (scan == 7'h7f)
               begin
                  st <= srb_pkg::S_IDLE;
               end
               else
               begin
                  scan <= scan + 7'h01;
               end
            end
            srb_pkg::S_SEND:
            begin
               // one or two bits per cycle
               sh        <= two_lane ? {sh[13:0], 2'h0} : {sh[14:0], 1'b0};
               bits_left <= bits_left - (two_lane ? 5'h02 : 5'h01);
               if (bits_left <= (two_lane ? 5'h02 : 5'h01))
               begin
                  st <= last ? srb_pkg::S_IDLE : srb_pkg::S_SCAN;
               end
            end
            default:
            begin
               st <= srb_pkg::S_IDLE;
            end
         endcase
      end
   end

   // serial lines and word start marker
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_ser   <= '0;
         o_frame <= 1'b0;
      end
      else if (st == srb_pkg::S_SEND)
      begin
         o_ser   <= {two_lane & sh[14], sh[15]};
         o_frame <= (bits_left == srb_pkg::WORD_BITS);
      end
      else
      begin
         o_ser   <= '0;
         o_frame <= 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         two_lane <= srb_pkg::TWO_DEF;
         lat      <= srb_pkg::LAT_DEF;
         mask     <= '0;
         inj_sel  <= '0;
         inj_go   <= 1'b0;
      end
      else
      begin
         inj_go <= 1'b0;
         if (wr_fire)
         begin
            if (i_awaddr == srb_pkg::A_CTRL)
            begin
               if (i_wstrb[0])
               begin
                  two_lane <= i_wdata[srb_pkg::C_TWO];
                  inj_go   <= i_wdata[srb_pkg::C_INJ];
               end
               if (i_wstrb[1])
               begin
                  lat <= i_wdata[srb_pkg::C_LAT_LO +: 8];
               end
            end
            else if (i_awaddr[7:4] == {2'h0, srb_pkg::A_MASK_HI})
            begin
               mask[i_awaddr[3:2]] <= merge(mask[i_awaddr[3:2]], i_wdata, i_wstrb);
            end
            else if (i_awaddr[7:4] == {2'h0, srb_pkg::A_INJ_HI})
            begin
               inj_sel[i_awaddr[3:2]] <= merge(inj_sel[i_awaddr[3:2]], i_wdata, i_wstrb);
            end
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_inject <= '0;
      end
      else
      begin
         o_inject <= inj_go ? inj_sel : '0;
      end
   end

   // register bus write channel
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         o_bvalid  <= 1'b0;
         o_bresp   <= srb_pkg::RESP_OK;
      end
      else
      begin
         o_awready <= ~o_awready & ~o_bvalid & i_awvalid & i_wvalid;
         o_wready  <= ~o_awready & ~o_bvalid & i_awvalid & i_wvalid;
         if (wr_fire)
         begin
            o_bvalid <= 1'b1;
            o_bresp  <= (i_awaddr == srb_pkg::A_CTRL || i_awaddr == srb_pkg::A_STAT
                         || i_awaddr[7:4] == {2'h0, srb_pkg::A_MASK_HI}
                         || i_awaddr[7:4] == {2'h0, srb_pkg::A_INJ_HI}) ? srb_pkg::RESP_OK : srb_pkg::RESP_ERR;
         end
         else if (i_bready)
         begin
            o_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= '0;
         o_rresp   <= srb_pkg::RESP_OK;
      end
      else
      begin
         o_arready <= ~o_arready & ~o_rvalid & i_arvalid;
         if (rd_fire)
         begin
            o_rvalid <= 1'b1;
            o_rresp  <= srb_pkg::RESP_OK;
            if (i_araddr == srb_pkg::A_CTRL)
            begin
               o_rdata <= {16'h0000, lat, 6'h00, 1'b0, two_lane};
            end
            else if (i_araddr == srb_pkg::A_STAT)
            begin
               o_rdata <= {lost, 7'h00, (st != srb_pkg::S_IDLE), 6'h00, ts_cnt};
            end
            else if (i_araddr[7:4] == {2'h0, srb_pkg::A_MASK_HI})
            begin
               o_rdata <= mask[i_araddr[3:2]];
            end
            else if (i_araddr[7:4] == {2'h0, srb_pkg::A_INJ_HI})
            begin
               o_rdata <= inj_sel[i_araddr[3:2]];
            end
            else
            begin
               o_rdata <= '0;
               o_rresp <= srb_pkg::RESP_ERR;
            end
         end
         else if (i_rready)
         begin
            o_rvalid <= 1'b0;
         end
      end
   end

   chk_mask_no_hit: assert property (@(posedge i_clk) disable iff (!i_rst_b) ##1 ((hv & $past(mask_flat)) == '0))
      else $error("masked channel holds a hit");
   chk_ts_advance: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $past(i_rst_b) |-> ts_cnt == $past(ts_cnt) + 10'h001)
      else $error("time stamp did not advance");
   chk_hit_format: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (st == srb_pkg::S_SCAN && match) |=> cur_word[11] && cur_word[15:12] == 4'h0
      && cur_word[6:0] == $past(scan) && cur_word[10:7] == $past(htot[scan]))
      else $error("bad hit word");
   chk_ts_format: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (st == srb_pkg::S_IDLE && trig_edge) |=> !cur_word[11] && cur_word[15:12] == 4'h0
      && !cur_word[10] && cur_word[9:0] == trig_ts_q)
      else $error("bad time stamp word");
   chk_word_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_frame |=> !o_frame [*7])
      else $error("word marker too close");
   chk_expire_drop: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (hv[0] && (ts_cnt - hts[0]) > {2'h0, lat} && !(~ds2[0] & ds3[0])) |=> !hv[0])
      else $error("expired hit kept");
   chk_defaults: assert property (@(posedge i_clk)
      !i_rst_b |=> lat == srb_pkg::LAT_DEF && two_lane == srb_pkg::TWO_DEF && mask == '0)
      else $error("default not applied");
   chk_read_answer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      rd_fire |=> o_rvalid ##0 (o_rvalid [*1]))
      else $error("read not answered");
   chk_write_answer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      wr_fire |=> o_bvalid && !o_awready)
      else $error("write not answered");
endmodule

// ### verification/srb_rx_model.sv
// receiver-board model: rebuilds 16-bit words from the serial lanes
`timescale 1ns/10ps
module srb_rx_model (
   input  wire logic        i_clk,
   input  wire logic        i_two,
   input  wire logic [1:0]  i_ser,
   input  wire logic        i_frame,
   output logic [15:0]      o_word,
   output logic             o_word_valid
);
   logic [15:0] shift = 16'h0000;
   logic [15:0] base;
   logic [15:0] next_shift;
   logic [3:0]  left = 4'h0;

   // a frame pulse starts a fresh word
   assign base = i_frame ? 16'h0000 : shift;
   assign next_shift = i_two ? {base[13:0], i_ser[0], i_ser[1]} : {base[14:0], i_ser[0]};

   always_ff @(posedge i_clk)
   begin
      shift        <= next_shift;
      o_word_valid <= 1'b0;
      if (i_frame)
      begin
         left <= i_two ? 4'h7 : 4'hf;
      end
      else if (left != 4'h0)
      begin
         left <= left - 4'h1;
         if (left == 4'h1)
         begin
            o_word       <= next_shift;
            o_word_valid <= 1'b1;
         end
      end
   end
endmodule

// ### verification/tb_strip_hit_readout_backend.sv
// testbench for the strip hit readout back-end
`timescale 1ns/10ps
module tb_strip_hit_readout_backend;
   localparam logic [7:0] A_MASK0 = 8'h10;
   localparam logic [7:0] A_INJ3  = 8'h2c;
   localparam logic [7:0] A_BAD   = 8'h40;
   logic         i_clk = 1'b0;
   logic         i_rst_b = 1'b0;
   logic [127:0] i_disc = '0;
   logic         i_trig = 1'b0;
   logic [9:0]   i_trig_ts = '0;
   logic         i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [7:0]   i_awaddr = '0, i_araddr = '0;
   logic [31:0]  i_wdata = '0;
   logic [3:0]   i_wstrb = '0;
   logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_frame, rx_valid;
   logic [1:0]   o_bresp, o_rresp, o_ser;
   logic [31:0]  o_rdata, rd;
   logic [127:0] o_inject;
   logic [15:0]  rx_word;
   logic [15:0]  rx_q [$];
   logic [9:0]   ts_cnt = '0, st1, st2, st3;
   logic         two = 1'b0;
   logic [1:0]   rs;
   int           err_total = 0, n_tests = 0, inj_hit = 0, inj_bad = 0;

   always #25 i_clk = ~i_clk;

   srb_readout dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_disc(i_disc), .i_trig(i_trig), .i_trig_ts(i_trig_ts),
      .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
      .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr), .i_rready(i_rready),
      .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
      .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_ser(o_ser), .o_frame(o_frame), .o_inject(o_inject));

   srb_rx_model rx_u (.i_clk(i_clk), .i_two(two), .i_ser(o_ser), .i_frame(o_frame), .o_word(rx_word),
      .o_word_valid(rx_valid));

   // stamp reference, word capture and test-pulse watch
   always @(posedge i_clk)
   begin
      ts_cnt <= i_rst_b ? ts_cnt + 10'h001 : 10'h000;
      if (rx_valid === 1'b1) rx_q.push_back(rx_word);
      if (o_inject === {1'b1, 127'h0}) inj_hit++;
      else if (o_inject !== '0) inj_bad++;
   end

   function automatic logic [15:0] tw(input logic [9:0] t);
      return {4'h0, 1'b0, 1'b0, t};
   endfunction

   function automatic logic [15:0] hw(input logic [6:0] s);
      return {4'h0, 1'b1, 4'hf, s};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic aw, w, b;
      i_awvalid <= 1'b1;
      i_awaddr  <= a;
      i_wvalid  <= 1'b1;
      i_wdata   <= d;
      i_wstrb   <= s;
      i_bready  <= 1'b1;
      do
      begin
         @(negedge i_clk);
         aw = o_awready === 1'b1;
         w  = o_wready === 1'b1;
         b  = o_bvalid === 1'b1;
         r  = o_bresp;
         @(posedge i_clk);
         if (aw) i_awvalid <= 1'b0;
         if (w) i_wvalid <= 1'b0;
      end
      while (!b);
      i_bready <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, v;
      i_arvalid <= 1'b1;
      i_araddr  <= a;
      i_rready  <= 1'b1;
      do
      begin
         @(negedge i_clk);
         ar = o_arready === 1'b1;
         v  = o_rvalid === 1'b1;
         d  = o_rdata;
         r  = o_rresp;
         @(posedge i_clk);
         if (ar) i_arvalid <= 1'b0;
      end
      while (!v);
      i_rready <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic trig(input logic [9:0] t);
      @(posedge i_clk);
      i_trig_ts <= t;
      @(posedge i_clk);
      i_trig <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_trig <= 1'b0;
   endtask

   task automatic pulse(input logic [127:0] v, output logic [9:0] st);
      @(posedge i_clk);
      i_disc <= i_disc | v;
      #1 st = ts_cnt;
      repeat (40) @(posedge i_clk);
      i_disc <= i_disc & ~v;
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (rx_q.size() == 0 && n < 400)
      begin
         @(posedge i_clk);
         n++;
      end
      do
      begin
         axi_rd(srb_pkg::A_STAT, rd, rs);
         n++;
      end
      while (rd[16] !== 1'b0 && n < 800);
      if (n >= 800) err_total++;
   endtask

   task automatic chk_stream(input int n, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
      logic [15:0] e [3];
      e = '{w0, w1, w2};
      chk(32'(rx_q.size()), 32'(n));
      for (int i = 0; i < n; i++) chk({16'h0, rx_q[i]}, {16'h0, e[i]});
      rx_q.delete();
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      close_out();
   end

   initial
   begin
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      axi_rd(srb_pkg::A_CTRL, rd, rs);
      chk(rd & 32'h0000_ff01, {16'h0, srb_pkg::LAT_DEF, 7'h0, srb_pkg::TWO_DEF});
      axi_rd(A_MASK0, rd, rs);
      chk(rd, 32'h0);
      axi_rd(srb_pkg::A_STAT, rd, rs);
      chk(rd & 32'hff01_0000, 32'h0);
      axi_rd(A_BAD, rd, rs);
      chk({rd[31:2], rs}, {30'h0, srb_pkg::RESP_ERR});
      axi_wr(A_BAD, 32'h1, 4'hf, rs);
      chk({30'h0, rs}, {30'h0, srb_pkg::RESP_ERR});
      axi_wr(A_MASK0, 32'h0000_0200, 4'hf, rs);
      axi_rd(A_MASK0, rd, rs);
      chk(rd, 32'h0000_0200);
      axi_wr(A_INJ3, 32'h8000_0000, 4'hf, rs);
      axi_wr(srb_pkg::A_CTRL, 32'h0000_ff02, 4'hf, rs);
      repeat (4) @(posedge i_clk);
      chk(32'(inj_hit), 32'h1);
      chk(32'(inj_bad), 32'h0);
      // strip 9 is masked, strips 3 and 7 share a later stamp
      pulse(128'h220, st1);
      trig(st1);
      pulse(128'h88, st2);
      wait_idle();
      chk_stream(2, tw(st1), hw(7'd5), 16'h0);
      axi_wr(srb_pkg::A_CTRL, 32'h0000_0001, 4'b0001, rs);
      two <= 1'b1;
      trig(st2);
      wait_idle();
      chk_stream(3, tw(st2), hw(7'd3), hw(7'd7));
      // a second trigger during readout is dropped and counted
      trig(10'h155);
      trig(10'h155);
      wait_idle();
      chk_stream(1, tw(10'h155), 16'h0, 16'h0);
      chk({24'h0, rd[31:24]}, 32'h1);
      axi_wr(srb_pkg::A_CTRL, 32'h0000_3c00, 4'b0010, rs);
      axi_rd(srb_pkg::A_CTRL, rd, rs);
      chk(rd & 32'h0000_ff01, 32'h0000_3c01);
      // strips 0 and 2 age past the latency before the trigger
      pulse(128'h5, st3);
      repeat (60) @(posedge i_clk);
      trig(st3);
      wait_idle();
      chk_stream(1, tw(st3), 16'h0, 16'h0);
      i_rst_b <= 1'b0;
      two     <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      axi_rd(srb_pkg::A_CTRL, rd, rs);
      chk(rd & 32'h0000_ff01, {16'h0, srb_pkg::LAT_DEF, 7'h0, srb_pkg::TWO_DEF});
      close_out();
   end
endmodule
